// file: rtl/l2cca_pkg.sv
/*
 * shared constants and types for the second-level cache configuration
 * access path: register offsets, field positions, command codes, states.
 * assumes a model-specific-register style access port and one core clock.
 */
`default_nettype none

package l2cca_pkg;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [11:0] OFF_ACCESS_DATA = 12'h088;
  localparam logic [11:0] OFF_GEOMETRY = 12'h116;
  localparam logic [11:0] OFF_ACCESS_ADDRESS = 12'h117;
  localparam logic [11:0] OFF_COMMAND_CONTROL = 12'h119;
  localparam logic [11:0] OFF_COMMAND_LAUNCH = 12'h11A;
  localparam logic [11:0] OFF_IN_PROGRESS = 12'h11B;

  // ****************************************************************
  // command codes
  // ****************************************************************
  localparam logic [4:0] CMD_DATA_READ_LRU_UPDATE = 5'h0C;
  localparam logic [4:0] CMD_TAG_READ_DATA_READ = 5'h0E;
  localparam logic [4:0] CMD_TAG_INQUIRE = 5'h0F;
  localparam logic [4:0] CMD_INTERNAL_CONTROL_READ = 5'h02;
  localparam logic [4:0] CMD_INTERNAL_CONTROL_WRITE = 5'h03;
  localparam logic [2:0] PFX_TAG_WRITE_DATA_READ = 3'h2;
  localparam logic [2:0] PFX_TAG_WRITE_DATA_WRITE = 3'h7;
  localparam logic [2:0] PFX_TAG_WRITE_ONLY = 3'h4;

  // ****************************************************************
  // line state and way codes
  // ****************************************************************
  localparam logic [1:0] LINE_MODIFIED = 2'h3;
  localparam logic [1:0] LINE_EXCLUSIVE = 2'h2;
  localparam logic [1:0] LINE_SHARED = 2'h1;
  localparam logic [1:0] LINE_INVALID = 2'h0;
  localparam logic [1:0] WAY_0 = 2'h0;
  localparam logic [1:0] WAY_3 = 2'h3;

  // ****************************************************************
  // geometry and enable control fields
  // ****************************************************************
  localparam int BUS_FRACTION_BIT = 25;
  localparam int HW_DISABLE_BIT = 23;
  localparam int ADDR_RANGE_LSB = 20;
  localparam int STATE_CHECK_BIT = 18;
  localparam int BANK_SIZE_LSB = 13;
  localparam int BANK_COUNT_LSB = 11;
  localparam int ASSOC_LSB = 9;
  localparam int L2_ENABLE_BIT = 8;
  localparam int CRITICAL_CHUNK_RETURN_PARITY_BIT = 7;
  localparam int ADDR_PARITY_BIT = 6;
  localparam int ECC_CHECK_BIT = 5;
  localparam int LATENCY_LSB = 1;
  localparam int CONFIGURED_BIT = 0;
  localparam logic [4:0] BANK_SIZE_RESET = 5'h01;

  // ****************************************************************
  // command control fields and masks
  // ****************************************************************
  localparam int CMD_LSB = 0;
  localparam int STATE_TO_LSB = 5;
  localparam int WAY_TO_LSB = 8;
  localparam int WAY_FROM_LSB = 10;
  localparam int STATE_FROM_LSB = 12;
  localparam int HIT_BIT = 17;
  localparam logic [63:0] ADDRESS_MASK = 64'h0000_0000_FFFF_FFF8;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [8:0] {
    KIND_NONE = 9'h001,
    KIND_DATA_READ_LRU_UPDATE = 9'h002,
    KIND_TAG_READ_DATA_READ = 9'h004,
    KIND_TAG_INQUIRE = 9'h008,
    KIND_INTERNAL_CONTROL_READ = 9'h010,
    KIND_INTERNAL_CONTROL_WRITE = 9'h020,
    KIND_TAG_WRITE_DATA_READ = 9'h040,
    KIND_TAG_WRITE_DATA_WRITE = 9'h080,
    KIND_TAG_WRITE_ONLY = 9'h100
  } l2cca_kind_type;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b01,
    SEQ_REQUEST = 2'b10
  } l2cca_seq_type;

  typedef struct packed {
    logic state_check;
    logic [4:0] bank_size;
    logic l2_enable;
    logic critical_chunk_return_parity;
    logic addr_parity;
    logic ecc_check;
    logic [3:0] latency;
    logic configured;
  } l2cca_geo_type;

  typedef struct packed {
    l2cca_seq_type seq;
    logic busy;
    logic [4:0] cmd_code;
    logic [1:0] state_to;
    logic [1:0] way_to;
    logic [1:0] way_from;
    logic [1:0] state_from;
    logic hit;
    logic [4:0] act_cmd;
    logic [1:0] act_state;
    logic [1:0] act_way;
    logic [63:0] address;
    logic [63:0] data;
    logic [63:0] rdata;
    logic rvalid;
  } l2cca_top_type;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic l2cca_is_tag_write(input l2cca_kind_type k);
    return k == KIND_TAG_WRITE_DATA_READ || k == KIND_TAG_WRITE_DATA_WRITE ||
      k == KIND_TAG_WRITE_ONLY;
  endfunction

  function automatic logic l2cca_returns_data(input l2cca_kind_type k);
    return k == KIND_DATA_READ_LRU_UPDATE || k == KIND_TAG_READ_DATA_READ ||
      k == KIND_TAG_WRITE_DATA_READ || k == KIND_INTERNAL_CONTROL_READ;
  endfunction

endpackage

`default_nettype wire

// file: rtl/l2cca_if.sv
/*
 * carriers between the access path top and its two helpers.
 * assumes both ends sit in the same clock domain.
 */
`default_nettype none

interface l2cca_cmd_if;
  import l2cca_pkg::*;
  logic [4:0] code;
  l2cca_kind_type kind;
  logic [1:0] tag_state;
  modport dec (input code, output kind, output tag_state);
  modport seq (output code, input kind, input tag_state);
endinterface

interface l2cca_cfg_if;
  logic wr_en;
  logic [63:0] wdata;
  logic hw_disable;
  logic [63:0] value;
  modport reg_side (input wr_en, input wdata, input hw_disable,
    output value);
  modport user (output wr_en, output wdata, output hw_disable,
    input value);
endinterface

`default_nettype wire

// file: rtl/l2cca_cmd_decode.sv
/*
 * decodes the five-bit cache command code into a one-hot kind.
 * assumes the code is stable while it is used.
 */
`default_nettype none

module l2cca_cmd_decode
  import l2cca_pkg::*;
(
  l2cca_cmd_if.dec cmd
);

  always_comb begin
    cmd.tag_state = cmd.code[1:0];
    case (cmd.code)
      CMD_DATA_READ_LRU_UPDATE: cmd.kind = KIND_DATA_READ_LRU_UPDATE;
      CMD_TAG_READ_DATA_READ: cmd.kind = KIND_TAG_READ_DATA_READ;
      CMD_TAG_INQUIRE: cmd.kind = KIND_TAG_INQUIRE;
      CMD_INTERNAL_CONTROL_READ: cmd.kind = KIND_INTERNAL_CONTROL_READ;
      CMD_INTERNAL_CONTROL_WRITE: cmd.kind = KIND_INTERNAL_CONTROL_WRITE;
      default: begin
        // prefix then line state in the low two bits
        case (cmd.code[4:2])
          PFX_TAG_WRITE_DATA_READ: cmd.kind = KIND_TAG_WRITE_DATA_READ;
          PFX_TAG_WRITE_DATA_WRITE: cmd.kind = KIND_TAG_WRITE_DATA_WRITE;
          PFX_TAG_WRITE_ONLY: cmd.kind = KIND_TAG_WRITE_ONLY;
          default: cmd.kind = KIND_NONE;
        endcase
      end
    endcase
  end

endmodule // l2cca_cmd_decode

`default_nettype wire

// file: rtl/l2cca_geometry_reg.sv
/*
 * geometry and enable control register: writable enables and sizes,
 * read-only geometry straps. assumes writes come as single-cycle strobes.
 */
`default_nettype none

module l2cca_geometry_reg
  import l2cca_pkg::*;
#(
  parameter logic BUS_FRACTION = 1'b0,
  parameter logic [2:0] ADDR_RANGE = 3'h3,
  parameter logic [1:0] BANK_COUNT = 2'h0,
  parameter logic [1:0] ASSOC = 2'h2
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  l2cca_cfg_if.reg_side cfg
);

  l2cca_geo_type geo_r;
  l2cca_geo_type geo_nxt;
  logic [4:0] size_w;

  always_comb begin
    geo_nxt = geo_r;
    size_w = cfg.wdata[BANK_SIZE_LSB+:5];
    if (cfg.wr_en) begin
      geo_nxt.state_check = cfg.wdata[STATE_CHECK_BIT];
      // non-one-hot sizes are dropped, the field keeps its value
      if ($onehot(size_w)) begin
        geo_nxt.bank_size = size_w;
      end
      geo_nxt.l2_enable = cfg.wdata[L2_ENABLE_BIT];
      geo_nxt.critical_chunk_return_parity = cfg.wdata[CRITICAL_CHUNK_RETURN_PARITY_BIT];
      geo_nxt.addr_parity = cfg.wdata[ADDR_PARITY_BIT];
      geo_nxt.ecc_check = cfg.wdata[ECC_CHECK_BIT];
      geo_nxt.latency = cfg.wdata[LATENCY_LSB+:4];
      geo_nxt.configured = cfg.wdata[CONFIGURED_BIT];
    end
    // a hardware-disabled cache cannot be switched on
    if (cfg.hw_disable) begin
      geo_nxt.l2_enable = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      geo_r <= '{bank_size: BANK_SIZE_RESET, default: '0};
    end else begin
      geo_r <= geo_nxt;
    end
  end

  always_comb begin
    cfg.value = '0;
    cfg.value[BUS_FRACTION_BIT] = BUS_FRACTION;
    cfg.value[HW_DISABLE_BIT] = cfg.hw_disable;
    cfg.value[ADDR_RANGE_LSB+:3] = ADDR_RANGE;
    cfg.value[STATE_CHECK_BIT] = geo_r.state_check;
    cfg.value[BANK_SIZE_LSB+:5] = geo_r.bank_size;
    cfg.value[BANK_COUNT_LSB+:2] = BANK_COUNT;
    cfg.value[ASSOC_LSB+:2] = ASSOC;
    cfg.value[L2_ENABLE_BIT] = geo_r.l2_enable;
    cfg.value[CRITICAL_CHUNK_RETURN_PARITY_BIT] = geo_r.critical_chunk_return_parity;
    cfg.value[ADDR_PARITY_BIT] = geo_r.addr_parity;
    cfg.value[ECC_CHECK_BIT] = geo_r.ecc_check;
    cfg.value[LATENCY_LSB+:4] = geo_r.latency;
    cfg.value[CONFIGURED_BIT] = geo_r.configured;
  end

endmodule // l2cca_geometry_reg

`default_nettype wire

// file: rtl/l2cca_access.sv
/*
 * second-level cache configuration access path: register port, command
 * sequencer toward the cache array, response capture.
 * assumes a register port with one-cycle read and write strobes and a
 * cache array that answers each request with a one-cycle acknowledge.
 */
`default_nettype none

// Notes on behaviour
// - codes 0C,0E,0F: read-lru, tag+data read, inquire
// - codes 02 and 03: internal control read, write
// - tag writes: prefix 010,111,100 plus line state
// - zero write to launch register starts command
// - busy bit 0 is one while command runs
// - bit 25 bus fraction, bit 23 hardware disable
// - bits 22:20 give physical address range
// - bit 18 enables line state error checking
// - bits 17:13 one-hot per-bank size, writable
// - bits 12:11 bank count, read only
// - bits 10:9 associativity, read only
// - bit 8 enables the second-level cache
// - bits 7,6,5 enable parity and ecc checks
// - bits 4:1 latency, bit 0 configured flag
// - bits 63:26, 24, 19 reserved, read zero
// - line state: 11 m, 10 e, 01 s, 00 i
// - way codes 00 to 11 for ways 0-3
// - control register captures hit, state, way
module l2cca_access
  import l2cca_pkg::*;
#(
  parameter logic BUS_FRACTION = 1'b0,
  parameter logic [2:0] ADDR_RANGE = 3'h3,
  parameter logic [1:0] BANK_COUNT = 2'h0,
  parameter logic [1:0] ASSOC = 2'h2
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [11:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [63:0] reg_wdata_in,
  output logic [63:0] reg_rdata_out,
  output logic reg_rvalid_out,
  input wire logic l2_hw_disable_in,
  output logic l2_req_out,
  output logic [4:0] l2_cmd_out,
  output logic [1:0] l2_state_out,
  output logic [1:0] l2_way_out,
  output logic [63:0] l2_addr_out,
  output logic [63:0] l2_wdata_out,
  input wire logic l2_ack_in,
  input wire logic l2_hit_in,
  input wire logic [1:0] l2_state_in,
  input wire logic [1:0] l2_way_in,
  input wire logic [63:0] l2_rdata_in,
  output logic l2_enable_out,
  output logic state_check_en_out,
  output logic critical_chunk_return_parity_en_out,
  output logic addr_parity_en_out,
  output logic ecc_check_en_out,
  output logic [3:0] l2_latency_out,
  output logic l2_configured_out,
  output logic [4:0] l2_bank_size_out
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  l2cca_cmd_if cmd_bus ();
  l2cca_cfg_if cfg_bus ();

  l2cca_cmd_decode u_decode (
    .cmd(cmd_bus.dec)
  );

  l2cca_geometry_reg #(
    .BUS_FRACTION(BUS_FRACTION),
    .ADDR_RANGE(ADDR_RANGE),
    .BANK_COUNT(BANK_COUNT),
    .ASSOC(ASSOC)
  ) u_geometry (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .cfg(cfg_bus.reg_side)
  );

  l2cca_top_type st_r;
  l2cca_top_type st_nxt;
  logic launch;
  logic done;
  logic [63:0] ctl_value;

  assign cmd_bus.code = st_r.act_cmd;
  assign cfg_bus.wr_en = reg_wr_in && reg_addr_in == OFF_GEOMETRY;
  assign cfg_bus.wdata = reg_wdata_in;
  assign cfg_bus.hw_disable = l2_hw_disable_in;

  // ****************************************************************
  // decode of register strobes
  // ****************************************************************
  // a non-zero launch value or a launch while busy is dropped
  assign launch = reg_wr_in && reg_addr_in == OFF_COMMAND_LAUNCH &&
    reg_wdata_in == '0 && !st_r.busy;
  assign done = st_r.seq == SEQ_REQUEST && l2_ack_in;

  always_comb begin
    ctl_value = '0;
    ctl_value[CMD_LSB+:5] = st_r.cmd_code;
    ctl_value[STATE_TO_LSB+:2] = st_r.state_to;
    ctl_value[WAY_TO_LSB+:2] = st_r.way_to;
    ctl_value[WAY_FROM_LSB+:2] = st_r.way_from;
    ctl_value[STATE_FROM_LSB+:2] = st_r.state_from;
    ctl_value[HIT_BIT] = st_r.hit;
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.rvalid = reg_rd_in;
    if (reg_rd_in) begin
      case (reg_addr_in)
        OFF_ACCESS_DATA: st_nxt.rdata = st_r.data;
        OFF_GEOMETRY: st_nxt.rdata = cfg_bus.value;
        OFF_ACCESS_ADDRESS: st_nxt.rdata = st_r.address;
        OFF_COMMAND_CONTROL: st_nxt.rdata = ctl_value;
        OFF_IN_PROGRESS: st_nxt.rdata = {63'h0, st_r.busy};
        default: st_nxt.rdata = '0;
      endcase
    end
    if (reg_wr_in) begin
      case (reg_addr_in)
        OFF_ACCESS_DATA: st_nxt.data = reg_wdata_in;
        // low three bits forced to zero whatever software writes
        OFF_ACCESS_ADDRESS: st_nxt.address = reg_wdata_in & ADDRESS_MASK;
        OFF_COMMAND_CONTROL: begin
          st_nxt.cmd_code = reg_wdata_in[CMD_LSB+:5];
          st_nxt.state_to = reg_wdata_in[STATE_TO_LSB+:2];
          st_nxt.way_to = reg_wdata_in[WAY_TO_LSB+:2];
        end
        default: begin
        end
      endcase
    end
    case (st_r.seq)
      SEQ_IDLE: begin
        if (launch) begin
          // snapshot so later control writes cannot disturb the array
          st_nxt.act_cmd = st_nxt.cmd_code;
          st_nxt.act_state = st_nxt.state_to;
          st_nxt.act_way = st_nxt.way_to;
          st_nxt.busy = 1'b1;
          st_nxt.seq = SEQ_REQUEST;
        end
      end
      SEQ_REQUEST: begin
        if (l2_ack_in) begin
          // response wins over a software write in the same cycle
          st_nxt.hit = l2_hit_in;
          st_nxt.state_from = l2_state_in;
          st_nxt.way_from = l2_way_in;
          if (l2cca_returns_data(cmd_bus.kind)) begin
            st_nxt.data = l2_rdata_in;
          end
          st_nxt.busy = 1'b0;
          st_nxt.seq = SEQ_IDLE;
        end
      end
      default: begin
        st_nxt.busy = 1'b0;
        st_nxt.seq = SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r <= '{seq: SEQ_IDLE, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign reg_rdata_out = st_r.rdata;
  assign reg_rvalid_out = st_r.rvalid;
  assign l2_req_out = st_r.seq == SEQ_REQUEST;
  assign l2_cmd_out = st_r.act_cmd;
  // tag writes carry their new line state inside the command code
  assign l2_state_out = l2cca_is_tag_write(cmd_bus.kind) ?
    cmd_bus.tag_state : st_r.act_state;
  assign l2_way_out = st_r.act_way;
  assign l2_addr_out = st_r.address;
  assign l2_wdata_out = st_r.data;
  assign l2_enable_out = cfg_bus.value[L2_ENABLE_BIT];
  assign state_check_en_out = cfg_bus.value[STATE_CHECK_BIT];
  assign critical_chunk_return_parity_en_out = cfg_bus.value[CRITICAL_CHUNK_RETURN_PARITY_BIT];
  assign addr_parity_en_out = cfg_bus.value[ADDR_PARITY_BIT];
  assign ecc_check_en_out = cfg_bus.value[ECC_CHECK_BIT];
  assign l2_latency_out = cfg_bus.value[LATENCY_LSB+:4];
  assign l2_configured_out = cfg_bus.value[CONFIGURED_BIT];
  assign l2_bank_size_out = cfg_bus.value[BANK_SIZE_LSB+:5];

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  a_launch_sets_busy: assert property (
    launch |=> st_r.busy && l2_req_out)
    else $error("launch did not start a command");

  a_nonzero_launch_dropped: assert property (
    reg_wr_in && reg_addr_in == OFF_COMMAND_LAUNCH && reg_wdata_in != '0 &&
      !st_r.busy |=> !st_r.busy)
    else $error("non-zero launch value started a command");

  a_busy_read_back: assert property (
    reg_rd_in && reg_addr_in == OFF_IN_PROGRESS |=>
      reg_rvalid_out && reg_rdata_out == {63'h0, $past(st_r.busy)})
    else $error("in-progress register read wrong value");

  a_busy_until_ack: assert property (
    l2_req_out && !l2_ack_in |=> st_r.busy)
    else $error("busy dropped before acknowledge");

  a_ack_ends_busy: assert property (
    done |=> !st_r.busy && !l2_req_out)
    else $error("busy still set after acknowledge");

  a_decode_read_cmds: assert property (
    cmd_bus.code == CMD_TAG_INQUIRE |-> cmd_bus.kind == KIND_TAG_INQUIRE)
    else $error("inquire code decoded wrongly");

  a_decode_ctrl_cmds: assert property (
    cmd_bus.code == CMD_INTERNAL_CONTROL_WRITE |->
      cmd_bus.kind == KIND_INTERNAL_CONTROL_WRITE)
    else $error("control write code decoded wrongly");

  a_tag_state_out: assert property (
    l2_req_out && cmd_bus.code[4:2] == PFX_TAG_WRITE_DATA_WRITE |->
      l2_state_out == l2_cmd_out[1:0] &&
      cmd_bus.kind == KIND_TAG_WRITE_DATA_WRITE)
    else $error("tag write state not taken from command");

  a_geometry_ro_bits: assert property (
    reg_rd_in && reg_addr_in == OFF_GEOMETRY |=>
      reg_rdata_out[HW_DISABLE_BIT] == $past(l2_hw_disable_in) &&
      reg_rdata_out[ADDR_RANGE_LSB+:3] == ADDR_RANGE &&
      reg_rdata_out[ASSOC_LSB+:2] == ASSOC)
    else $error("geometry read-only fields wrong");

  a_reserved_zero: assert property (
    reg_rd_in && reg_addr_in == OFF_GEOMETRY |=>
      reg_rdata_out[63:26] == '0 && !reg_rdata_out[24] && !reg_rdata_out[19])
    else $error("reserved geometry bits not zero");

  a_enable_follows: assert property (
    cfg_bus.wr_en && !l2_hw_disable_in |=>
      l2_enable_out == $past(reg_wdata_in[L2_ENABLE_BIT]))
    else $error("cache enable did not follow write");

  a_response_capture: assert property (
    done |=> ctl_value[HIT_BIT] == $past(l2_hit_in) &&
      ctl_value[STATE_FROM_LSB+:2] == $past(l2_state_in) &&
      ctl_value[WAY_FROM_LSB+:2] == $past(l2_way_in))
    else $error("lookup response not captured");

  a_hit_stored: assert property (
    done |=> st_r.hit == $past(l2_hit_in) &&
      st_r.way_from == $past(l2_way_in))
    else $error("hit or way not stored on acknowledge");

  a_request_held: assert property (
    l2_req_out && !l2_ack_in |=> l2_req_out && $stable(l2_cmd_out) &&
      $stable(l2_way_out) && $stable(l2_state_out))
    else $error("request changed before acknowledge");

  a_data_capture: assert property (
    done && l2cca_returns_data(cmd_bus.kind) |=>
      l2_wdata_out == $past(l2_rdata_in))
    else $error("returned data not captured");

  a_ctl_read_image: assert property (
    reg_rd_in && reg_addr_in == OFF_COMMAND_CONTROL |=>
      reg_rdata_out[STATE_TO_LSB+:2] == $past(st_r.state_to) &&
      reg_rdata_out[63:18] == '0 && !reg_rdata_out[7])
    else $error("control register read image wrong");

  a_count_read_only: assert property (
    reg_rd_in && reg_addr_in == OFF_GEOMETRY |=>
      reg_rdata_out[BANK_COUNT_LSB+:2] == BANK_COUNT &&
      reg_rdata_out[BUS_FRACTION_BIT] == BUS_FRACTION)
    else $error("bank count or bus fraction wrong");

  a_size_one_hot: assert property (
    $onehot(l2_bank_size_out))
    else $error("bank size not one-hot");

  a_size_bad_kept: assert property (
    cfg_bus.wr_en && !$onehot(reg_wdata_in[BANK_SIZE_LSB+:5]) |=>
      $stable(l2_bank_size_out))
    else $error("non-one-hot bank size was taken");

  a_state_check_follows: assert property (
    cfg_bus.wr_en |=>
      state_check_en_out == $past(reg_wdata_in[STATE_CHECK_BIT]))
    else $error("state check enable did not follow write");

  a_checks_follow: assert property (
    cfg_bus.wr_en |=> {critical_chunk_return_parity_en_out, addr_parity_en_out,
      ecc_check_en_out} == $past(reg_wdata_in[ECC_CHECK_BIT+:3]))
    else $error("check enables did not follow write");

  a_latency_follows: assert property (
    cfg_bus.wr_en |=> l2_latency_out == $past(reg_wdata_in[LATENCY_LSB+:4])
      && l2_configured_out == $past(reg_wdata_in[CONFIGURED_BIT]))
    else $error("latency or configured flag did not follow write");

  a_hw_disable_off: assert property (
    l2_hw_disable_in |=> !l2_enable_out)
    else $error("cache enabled while hardware disabled");

  c_inquire_done: cover property (
    launch && st_nxt.act_cmd == CMD_TAG_INQUIRE ##[1:20] done);
  c_tag_write_done: cover property (
    l2_req_out && l2cca_is_tag_write(cmd_bus.kind) && l2_ack_in);
  c_enable_cache: cover property (cfg_bus.wr_en ##1 l2_enable_out);
  c_busy_polled: cover property (
    st_r.busy && reg_rd_in && reg_addr_in == OFF_IN_PROGRESS);

endmodule // l2cca_access

`default_nettype wire

// file: verif/l2cca_array_model.sv
/* cache array stand-in: acks each request after a set delay.
   assumes one clock shared with the access path. */
`default_nettype none
module l2cca_array_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic req_in,
  input wire logic [3:0] delay_in,
  input wire logic [4:0] resp_in,
  input wire logic [63:0] data_in,
  output logic ack_out,
  output logic [4:0] resp_out,
  output logic [63:0] rdata_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // answer path
  // ****
  logic [3:0] cnt_r;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_r <= 4'h0;
      ack_out <= 1'b0;
      resp_out <= 5'h00;
      rdata_out <= 64'h0;
    end else if (req_in && !ack_out && cnt_r == delay_in) begin
      ack_out <= 1'b1;
      cnt_r <= 4'h0;
      resp_out <= resp_in;
      rdata_out <= data_in;
    end else begin
      ack_out <= 1'b0;
      cnt_r <= (req_in && !ack_out) ? cnt_r + 4'h1 : 4'h0;
      // lines released: keep moving so stale values never match
      resp_out <= ~resp_out;
      rdata_out <= ~rdata_out;
    end
  end
endmodule // l2cca_array_model
`default_nettype wire

// file: verif/l2cca_access_tb.sv
/* self-checking bench for the cache configuration access path.
   assumes the array stand-in model and default geometry straps. */
`default_nettype none
module l2cca_access_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // harness
  // ****
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [11:0] reg_a = 12'h000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [63:0] reg_d = 64'h0;
  logic hw_dis = 1'b0;
  logic [3:0] dly = 4'h0;
  logic [4:0] resp = 5'h00;
  logic [63:0] rsp_d = 64'h0;
  logic [8:0] seen_c;
  logic [63:0] seen_a, seen_d;
  int err_total = 0;
  int tests_run = 0;
  wire logic rvalid, req, ack;
  wire logic [63:0] rdata, l2a, l2d, mdata;
  wire logic [4:0] cmd, mresp;
  wire logic [1:0] st, way;
  wire logic [14:0] o;
  logic [4:0] codes [9] = '{5'h0C, 5'h0E, 5'h0F, 5'h02, 5'h03, 5'h0B,
    5'h1E, 5'h10, 5'h09};
  l2cca_access dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .reg_addr_in(reg_a), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
    .reg_wdata_in(reg_d), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
    .l2_hw_disable_in(hw_dis), .l2_req_out(req), .l2_cmd_out(cmd),
    .l2_state_out(st), .l2_way_out(way), .l2_addr_out(l2a),
    .l2_wdata_out(l2d), .l2_ack_in(ack), .l2_hit_in(mresp[4]),
    .l2_state_in(mresp[3:2]), .l2_way_in(mresp[1:0]),
    .l2_rdata_in(mdata), .l2_enable_out(o[14]),
    .state_check_en_out(o[13]), .critical_chunk_return_parity_en_out(o[12]),
    .addr_parity_en_out(o[11]), .ecc_check_en_out(o[10]),
    .l2_latency_out(o[9:6]), .l2_configured_out(o[5]),
    .l2_bank_size_out(o[4:0]));
  l2cca_array_model array (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .req_in(req), .delay_in(dly), .resp_in(resp), .data_in(rsp_d),
    .ack_out(ack), .resp_out(mresp), .rdata_out(mdata));
  initial forever #5 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    if (req === 1'b1) begin
      seen_c = {cmd, st, way};
      seen_a = l2a;
      seen_d = l2d;
    end
  end
  // ****
  // shared tasks
  // ****
  task automatic chk(input string n, input logic [63:0] s,
    input logic [63:0] e);
    tests_run++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [63:0] d);
    @(posedge clk_in);
    #1;
    reg_a = a;
    reg_d = d;
    reg_wr = 1'b1;
    @(posedge clk_in);
    #1;
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [63:0] v);
    @(posedge clk_in);
    #1;
    reg_a = a;
    reg_rd = 1'b1;
    @(posedge clk_in);
    #1;
    reg_rd = 1'b0;
    chk("rvalid", {63'h0, rvalid}, 64'h1);
    v = rdata;
  endtask
  task automatic rc(input logic [11:0] a, input logic [63:0] e,
    input string n);
    logic [63:0] v;
    rd(a, v);
    chk(n, v, e);
  endtask
  // enable pins mirror the geometry fields
  function automatic logic [63:0] pins(input logic [63:0] g);
    return {49'h0, g[8], g[18], g[7], g[6], g[5], g[4:1], g[0], g[17:13]};
  endfunction
  // ****
  // scenarios
  // ****
  task automatic t_reset;
    chk("pins", 64'(o), 64'h1);
    rc(12'h116, 64'h0030_2400, "geo");
    rc(12'h11B, 64'h0, "busy");
    rc(12'h11A, 64'h0, "launch");
    rc(12'h200, 64'h0, "unmapped");
  endtask
  task automatic t_geo;
    logic [63:0] e;
    wr(12'h116, '1);
    rc(12'h116, 64'h0034_25FF, "geo");
    chk("pins", 64'(o), pins(64'h0034_25FF));
    for (int k = 0; k < 5; k++) begin
      e = 64'h0030_0400 | (64'h2000 << k);
      wr(12'h116, e);
      rc(12'h116, e, "size");
    end
    hw_dis = 1'b1;
    wr(12'h116, 64'h0100);
    rc(12'h116, 64'h00B2_0400, "hwdis");
    chk("enable", 64'(o[14]), 64'h0);
    hw_dis = 1'b0;
  endtask
  task automatic t_cmd;
    logic [4:0] c;
    logic [1:0] w;
    logic [63:0] v, d;
    logic tw, dr;
    for (int i = 0; i < 9; i++) begin
      c = codes[i];
      w = i[1:0];
      tw = c[4:2] inside {3'h2, 3'h7, 3'h4};
      dr = c inside {5'h0C, 5'h0E, 5'h02} || c[4:2] == 3'h2;
      d = 64'h5A5A_0000_0000_0000 | 64'(i);
      wr(12'h119, {54'h0, w, 1'b0, 2'h2, c});
      wr(12'h117, 64'hFFFF_FFFF_FFFF_FFF8);
      wr(12'h088, d);
      dly = 4'(i);
      resp = {i[0], ~w, w + 2'h1};
      rsp_d = ~d;
      wr(12'h11A, 64'h0);
      if (i > 3) rc(12'h11B, 64'h1, "busy");
      v = 64'h1;
      for (int k = 0; v !== 64'h0; k++) begin
        if (k == 20) begin
          err_total++;
          tally_and_finish;
        end
        rd(12'h11B, v);
      end
      chk("cmd", 64'(seen_c), 64'({c, tw ? c[1:0] : 2'h2, w}));
      chk("addr", seen_a, 64'hFFFF_FFF8);
      chk("wdata", seen_d, d);
      rc(12'h119, {46'h0, i[0], 3'h0, ~w, w + 2'h1, w, 1'b0, 2'h2, c},
        "ctl");
      rc(12'h088, dr ? ~d : d, "data");
    end
  endtask
  task automatic t_bad;
    wr(12'h11A, 64'h1);
    repeat (3) @(posedge clk_in);
    #1;
    chk("req", 64'(req), 64'h0);
    rc(12'h11B, 64'h0, "busy");
  endtask
  initial begin
    repeat (10) @(posedge clk_in);
    #1;
    rst_n_in = 1'b1;
    t_reset;
    t_geo;
    t_cmd;
    t_bad;
    tally_and_finish;
  end
endmodule // l2cca_access_tb
`default_nettype wire
